// file: rtl/bus_mode_pkg.sv
`default_nettype none
package bus_mode_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Processor modes
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_EXPAND = 2'h1;
	localparam logic [1:0] MODE_MICRO = 2'h2;
	localparam logic [1:0] MODE_EVAL = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_MODE0 = 8'h00;
	localparam logic [7:0] OFS_MODE1 = 8'h04;
	localparam logic [7:0] OFS_OSC0 = 8'h08;
	localparam logic [7:0] OFS_PFC = 8'h0C;
	localparam logic [7:0] OFS_GPIO0 = 8'h10;
	localparam logic [7:0] OFS_GPIO4 = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;

	// Field positions
	localparam int MODE0_WAIT_BIT = 2;
	localparam int MODE0_AUX_BIT = 7;
	localparam int MODE1_WSEL_BIT = 0;
	localparam int OSC0_SOD_BIT = 6;
	localparam int PFC_STBY_BIT = 0;

	// Values after reset
	localparam logic [7:0] MODE0_RST = 8'h00;
	localparam logic [7:0] MODE1_RST = 8'h00;
	localparam logic [7:0] OSC0_RST = 8'h00;
	localparam logic [7:0] PFC_RST = 8'h00;
	localparam logic [15:0] GPIO_RST = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Timing in clock cycles and half periods of phi
	localparam logic [3:0] PHI_HALF_LAST = 4'h1;
	localparam logic [3:0] ADDR_HALVES = 4'h2;
	localparam logic [3:0] LEN_NOWAIT = 4'h4;
	localparam logic [3:0] LEN_WAIT15 = 4'h6;
	localparam logic [3:0] LEN_WAIT20 = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// Memory map of the external bus
	localparam logic [23:0] P4_DATA_ADDR = 24'h00000A;
	localparam logic [23:0] P4_DIR_ADDR = 24'h00000C;
	localparam logic [23:0] INT_RAM_LO = 24'h000000;
	localparam logic [23:0] INT_RAM_HI = 24'h000FFF;
	localparam logic [23:0] INT_ROM_LO = 24'h001000;
	localparam logic [23:0] INT_ROM_HI = 24'h00FFFF;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA, BUS_HOLD} bus_state_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_t;

	typedef struct packed {
		logic width_flag;
		logic queue_flush;
		logic data_valid;
		logic opcode_valid;
	} eval_flags_t;

endpackage
`default_nettype wire

// file: rtl/phi_gen.sv
`default_nettype none
module phi_gen (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	output logic half_tick,
	output logic phi_fall,
	output logic aux_level
);
	import bus_mode_pkg::*;

	logic [3:0] cnt_r;
	logic phi_r;
	logic aux_r;
	wire div_tick = (cnt_r == PHI_HALF_LAST);

	// Phi may only rise when not stalled; the aux clock never looks at the stall
	assign half_tick = div_tick & (phi_r | ~stall);
	assign phi_fall = div_tick & phi_r;
	assign aux_level = aux_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_r <= 4'h0;
			phi_r <= 1'b0;
			aux_r <= 1'b0;
		end
		else
		begin
			cnt_r <= div_tick ? 4'h0 : cnt_r + 4'h1;
			if (div_tick)
			begin
				aux_r <= ~aux_r;
				phi_r <= ~phi_r & ~stall;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/access_timer.sv
`default_nettype none
module access_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [3:0] load_val,
	input wire logic tick,
	output logic done
);
	logic [3:0] cnt_r;

	assign done = tick & (cnt_r == 4'h1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_r <= 4'h0;
		else if (load)
			cnt_r <= load_val;
		else if (tick && cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	end
endmodule
`default_nettype wire

// file: rtl/ext_bus_ctrl.sv
`default_nettype none
module ext_bus_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic mode_strap_pin,
	input wire logic mode_strap_hv,
	input wire logic bus_width_pin,
	input wire logic bus_width_hv,
	input wire logic cpu_req,
	input wire logic [23:0] cpu_addr,
	input wire logic cpu_write,
	input wire logic cpu_word,
	input wire logic [15:0] cpu_wdata,
	input wire logic [15:0] int_rdata,
	output logic cpu_ack,
	output logic [15:0] cpu_rdata,
	input wire logic standby_in,
	input wire bus_mode_pkg::eval_flags_t eval_in,
	input wire logic [7:0] p0_in,
	input wire logic [7:0] p1_in,
	input wire logic [7:0] p2_in,
	input wire logic [7:0] p3_in,
	input wire logic [7:0] p4_in,
	output bus_mode_pkg::pin_drive_t p0_drive,
	output bus_mode_pkg::pin_drive_t p1_drive,
	output bus_mode_pkg::pin_drive_t p2_drive,
	output bus_mode_pkg::pin_drive_t p3_drive,
	output bus_mode_pkg::pin_drive_t p4_drive,
	output logic enable_out
);
	import bus_mode_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
		input logic [23:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [3:0] access_halves(input logic internal, input logic wait_bit,
		input logic wsel);
		if (internal || wait_bit)
			access_halves = LEN_NOWAIT;
		else if (wsel)
			access_halves = LEN_WAIT15;
		else
			access_halves = LEN_WAIT20;
	endfunction

	function automatic logic [7:0] reg_index(input logic [7:0] a);
		reg_index = {2'h0, a[7:2]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Registers and state

	logic [7:0] mode0_r;
	logic [1:0] pm_r;
	logic [7:0] mode1_r;
	logic [7:0] osc0_r;
	logic [7:0] pfc_r;
	logic [15:0] gpio_r [0:4];
	logic strap_hi_r;
	logic strap_hv_r;

	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic aw_hold_r, w_hold_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;

	bus_state_t state_r;
	logic [23:0] acc_addr_r;
	logic acc_write_r, acc_word_r, acc_int_r, acc_wide_r;
	logic [15:0] acc_wdata_r;
	logic grant_n_r;
	logic float_r;
	logic cpu_ack_r;
	logic [15:0] cpu_rdata_r;
	pin_drive_t drive_r [0:4];
	logic enable_r;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode

	wire ext_mode = (pm_r != MODE_SINGLE);
	wire eval_mode = (pm_r == MODE_EVAL);
	wire micro_mode = (pm_r == MODE_MICRO);
	wire sod = osc0_r[OSC0_SOD_BIT];
	wire stby_sel = pfc_r[PFC_STBY_BIT];
	wire wait_bit = mode0_r[MODE0_WAIT_BIT];
	wire wsel = mode1_r[MODE1_WSEL_BIT];
	wire [1:0] strap_mode = mode_strap_hv ? MODE_EVAL :
		(mode_strap_pin ? MODE_MICRO : MODE_SINGLE);

	// Requests and waits on port 4 only count once the bus pins exist
	wire hold_req = ext_mode & ~p4_in[0];
	wire stall = ext_mode & ~p4_in[1];

	wire half_tick, phi_fall, aux_level, timer_done;

	phi_gen u_phi (
		.aclk(aclk),
		.aresetn(aresetn),
		.stall(stall),
		.half_tick(half_tick),
		.phi_fall(phi_fall),
		.aux_level(aux_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Access classification

	wire p4_reg = (cpu_addr == P4_DATA_ADDR) || (cpu_addr == P4_DIR_ADDR);
	wire rom_area = in_range(cpu_addr, INT_ROM_LO, INT_ROM_HI);
	wire req_int = in_range(cpu_addr, INT_RAM_LO, INT_RAM_HI) | (rom_area & ~micro_mode)
		| (eval_mode & p4_reg);
	wire req_wide = ~bus_width_pin | (eval_mode & (p4_reg | (bus_width_hv & rom_area)));
	wire [3:0] req_len = access_halves(req_int, wait_bit, wsel);
	wire start_acc = (state_r == BUS_IDLE) & phi_fall & cpu_req & ~cpu_ack_r & ~float_r
		& ~hold_req;
	wire take_hold = (state_r == BUS_IDLE) & phi_fall & hold_req;
	wire timer_load = start_acc | ((state_r == BUS_ADDR) & timer_done);
	wire [3:0] timer_val = start_acc ? ADDR_HALVES :
		access_halves(acc_int_r, wait_bit, wsel) - ADDR_HALVES;

	access_timer u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(timer_load),
		.load_val(timer_val),
		.tick(half_tick),
		.done(timer_done)
	);

	wire data_term = (state_r == BUS_DATA);
	wire data_done = data_term & timer_done;
	wire odd_lane = eval_mode | acc_wide_r;
	wire [15:0] ext_rdata = acc_wide_r ? {p1_in, p2_in} : {p2_in, p2_in};
	// Internal data wins so stray levels on the lanes never reach the core
	wire [15:0] read_data = acc_int_r ? int_rdata : ext_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive next values

	wire e_strobe = ~(data_term & ~(sod & acc_int_r));
	wire e_nxt = ~ext_mode ? (~sod & ~data_term) :
		(standby_in ? ~(sod & stby_sel) : e_strobe);
	wire aux_pin_on = eval_mode | (micro_mode & ~sod) | (~micro_mode & mode0_r[MODE0_AUX_BIT]);
	wire bus_oe = ~float_r;
	wire acc_busy = (state_r == BUS_ADDR) | data_term;
	wire [7:0] p2_wbyte = (acc_wide_r | ~acc_addr_r[0]) ? acc_wdata_r[7:0] : acc_wdata_r[15:8];
	wire upper_n = ~(acc_busy & (acc_addr_r[0] | (acc_word_r & acc_wide_r)));
	wire [3:0] p3_ctl = {grant_n_r, (state_r == BUS_ADDR), upper_n,
		~(acc_busy & acc_write_r)};
	wire [7:0] p4_eval = {1'b0, eval_in.opcode_valid, eval_in.data_valid, eval_in.queue_flush,
		eval_in.width_flag, aux_level, 2'h0};

	pin_drive_t d_nxt [0:4];

	always_comb
	begin
		for (int i = 0; i < 5; i++)
		begin
			d_nxt[i].out = gpio_r[i][7:0];
			d_nxt[i].oe = gpio_r[i][15:8];
		end
		if (ext_mode)
		begin
			d_nxt[0].out = acc_addr_r[7:0];
			d_nxt[0].oe = {8{bus_oe}};
			d_nxt[1].out = (data_term & odd_lane) ? acc_wdata_r[15:8] : acc_addr_r[15:8];
			d_nxt[1].oe = {8{bus_oe & ~(data_term & odd_lane & ~acc_write_r)}};
			d_nxt[2].out = data_term ? p2_wbyte : acc_addr_r[23:16];
			d_nxt[2].oe = {8{bus_oe & ~(data_term & ~acc_write_r)}};
			d_nxt[3].out = {gpio_r[3][7:4], p3_ctl};
			d_nxt[3].oe = {gpio_r[3][15:12], 2'h3, bus_oe, bus_oe};
			d_nxt[4].oe[1:0] = 2'h0;
			if (eval_mode)
			begin
				d_nxt[4].out = p4_eval;
				d_nxt[4].oe = 8'h7C;
			end
		end
		if (aux_pin_on)
		begin
			d_nxt[4].out[2] = aux_level;
			d_nxt[4].oe[2] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus sequencer

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= BUS_IDLE;
			acc_addr_r <= 24'h000000;
			acc_write_r <= 1'b0;
			acc_word_r <= 1'b0;
			acc_int_r <= 1'b0;
			acc_wide_r <= 1'b0;
			acc_wdata_r <= 16'h0000;
			grant_n_r <= 1'b1;
			float_r <= 1'b0;
			cpu_ack_r <= 1'b0;
			cpu_rdata_r <= 16'h0000;
		end
		else
		begin
			cpu_ack_r <= data_done;
			if (phi_fall)
				float_r <= ~grant_n_r;
			case (state_r)
				BUS_IDLE:
				begin
					if (take_hold)
					begin
						grant_n_r <= 1'b0;
						state_r <= BUS_HOLD;
					end
					else if (start_acc)
					begin
						acc_addr_r <= cpu_addr;
						acc_write_r <= cpu_write;
						acc_word_r <= cpu_word;
						acc_int_r <= req_int;
						acc_wide_r <= req_wide;
						acc_wdata_r <= cpu_wdata;
						state_r <= BUS_ADDR;
					end
				end
				BUS_ADDR:
				begin
					if (timer_done)
						state_r <= BUS_DATA;
				end
				BUS_DATA:
				begin
					if (timer_done)
					begin
						cpu_rdata_r <= read_data;
						state_r <= BUS_IDLE;
					end
				end
				BUS_HOLD:
				begin
					if (phi_fall && !hold_req)
					begin
						grant_n_r <= 1'b1;
						state_r <= BUS_IDLE;
					end
				end
				default:
					state_r <= BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 5; i++)
				drive_r[i] <= '0;
			enable_r <= 1'b1;
		end
		else
		begin
			for (int i = 0; i < 5; i++)
				drive_r[i] <= d_nxt[i];
			enable_r <= e_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register slave

	wire aw_take = awvalid & awready_r;
	wire w_take = wvalid & wready_r;
	wire wr_commit = aw_hold_r & w_hold_r & ~bvalid_r;
	wire aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_commit;
	wire w_hold_nxt = (w_hold_r | w_take) & ~wr_commit;
	wire ar_take = arvalid & arready_r;
	wire rvalid_nxt = ar_take | (rvalid_r & ~rready);
	wire [7:0] widx = reg_index(awaddr_r);
	wire [7:0] ridx = reg_index(araddr);
	wire w_gpio = (awaddr_r >= OFS_GPIO0) && (awaddr_r <= OFS_GPIO4);
	wire r_gpio = (araddr >= OFS_GPIO0) && (araddr <= OFS_GPIO4);
	wire [2:0] wg = 3'(widx - reg_index(OFS_GPIO0));
	wire [2:0] rg = 3'(ridx - reg_index(OFS_GPIO0));
	wire w_known = w_gpio | (awaddr_r == OFS_MODE0) | (awaddr_r == OFS_MODE1)
		| (awaddr_r == OFS_OSC0) | (awaddr_r == OFS_PFC) | (awaddr_r == OFS_STATUS);
	wire [1:0] pm_wr = wdata_r[1:0];
	// Only a single-chip start may leave for the two software modes
	wire pm_ok = ~strap_hi_r & ~strap_hv_r & ((pm_wr == MODE_EXPAND) | (pm_wr == MODE_MICRO)
		| (pm_wr == MODE_SINGLE));
	wire [7:0] pin_in_sel [0:4];
	assign pin_in_sel[0] = p0_in;
	assign pin_in_sel[1] = p1_in;
	assign pin_in_sel[2] = p2_in;
	assign pin_in_sel[3] = p3_in;
	assign pin_in_sel[4] = p4_in;
	wire [31:0] status_w = {20'h0, eval_mode & ~p4_in[7], float_r, ~grant_n_r, acc_busy,
		strap_hv_r, strap_hi_r, 6'(pm_r)};
	wire [31:0] rd_w = (araddr == OFS_MODE0) ? {24'h0, mode0_r[7:2], pm_r} :
		(araddr == OFS_MODE1) ? {24'h0, mode1_r} :
		(araddr == OFS_OSC0) ? {24'h0, osc0_r} :
		(araddr == OFS_PFC) ? {24'h0, pfc_r} :
		(araddr == OFS_STATUS) ? status_w :
		(r_gpio && rg < 3'h5 && araddr[1:0] == 2'h0) ?
			{16'h0, gpio_r[rg][15:8], pin_in_sel[rg]} : 32'h0;
	wire r_known = (araddr == OFS_MODE0) | (araddr == OFS_MODE1) | (araddr == OFS_OSC0)
		| (araddr == OFS_PFC) | (araddr == OFS_STATUS) | r_gpio;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strap_hi_r <= mode_strap_pin;
			strap_hv_r <= mode_strap_hv;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode0_r <= MODE0_RST;
			pm_r <= strap_mode;
			mode1_r <= MODE1_RST;
			osc0_r <= OSC0_RST;
			pfc_r <= PFC_RST;
			for (int i = 0; i < 5; i++)
				gpio_r[i] <= GPIO_RST;
		end
		else if (wr_commit && w_known)
		begin
			if (awaddr_r == OFS_MODE0 && wstrb_r[0])
			begin
				mode0_r <= wdata_r[7:0];
				if (pm_ok)
					pm_r <= pm_wr;
			end
			if (awaddr_r == OFS_MODE1 && wstrb_r[0])
				mode1_r <= wdata_r[7:0];
			if (awaddr_r == OFS_OSC0 && wstrb_r[0])
				osc0_r <= wdata_r[7:0];
			if (awaddr_r == OFS_PFC && wstrb_r[0])
				pfc_r <= wdata_r[7:0];
			if (w_gpio && wg < 3'h5 && awaddr_r[1:0] == 2'h0)
			begin
				if (wstrb_r[0])
					gpio_r[wg][7:0] <= wdata_r[7:0];
				if (wstrb_r[1])
					gpio_r[wg][15:8] <= wdata_r[15:8];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			bvalid_r <= 1'b0;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bresp_r <= RESP_OKAY;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
		end
		else
		begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awready_r <= ~aw_hold_nxt;
			wready_r <= ~w_hold_nxt;
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (aw_take)
				awaddr_r <= awaddr;
			if (w_take)
			begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (wr_commit)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= (w_known && awaddr_r != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid_r <= 1'b0;
			if (ar_take)
			begin
				rdata_r <= rd_w;
				rresp_r <= r_known ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign cpu_ack = cpu_ack_r;
	assign cpu_rdata = cpu_rdata_r;
	assign p0_drive = drive_r[0];
	assign p1_drive = drive_r[1];
	assign p2_drive = drive_r[2];
	assign p3_drive = drive_r[3];
	assign p4_drive = drive_r[4];
	assign enable_out = enable_r;

endmodule
`default_nettype wire

// file: dv/ext_bus_ctrl_checker.sv
`default_nettype none
module ext_bus_ctrl_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cpu_req,
	input wire logic [23:0] cpu_addr,
	input wire logic cpu_word,
	input wire logic bus_width_pin,
	input wire logic standby_in,
	input wire logic [7:0] p4_in,
	input wire bus_mode_pkg::pin_drive_t p0_drive,
	input wire bus_mode_pkg::pin_drive_t p1_drive,
	input wire bus_mode_pkg::pin_drive_t p2_drive,
	input wire bus_mode_pkg::pin_drive_t p3_drive,
	input wire logic enable_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import bus_mode_pkg::*;
	logic ext;
	logic ale;
	assign ext = p0_drive.oe == 8'hFF;
	assign ale = p3_drive.out[2] && p3_drive.oe[2];
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	// Past enable keeps the bus turning on after reset out of the grant checks
	sequence s_grant_fall;
		$fell(p3_drive.out[3]) && p3_drive.oe[3] && $past(p3_drive.oe[3]) && ext;
	endsequence
	sequence s_grant_rise;
		$rose(p3_drive.out[3]) && $past(p3_drive.oe[3]) && p0_drive.oe == 8'h00;
	endsequence
	sequence s_stall;
		(ext && !p4_in[1])[*8];
	endsequence
	property p_reset_quiet;
		$rose(aresetn) |-> p0_drive.oe == 8'h00 && enable_out;
	endproperty
	property p_float_on;
		s_grant_fall |-> ext[*3] ##[1:3] (p0_drive.oe == 8'h00 && p3_drive.oe[1:0] == 2'h0);
	endproperty
	property p_float_off;
		s_grant_rise |-> (p0_drive.oe == 8'h00)[*3] ##[1:3] ext;
	endproperty
	property p_grant_idle;
		s_grant_fall |-> enable_out && !ale;
	endproperty
	property p_stall;
		s_stall |-> $stable(enable_out) && $stable(ale);
	endproperty
	property p_read_lanes;
		ext && !enable_out && p3_drive.out[0] && !bus_width_pin && !standby_in
			|-> p1_drive.oe == 8'h00 && p2_drive.oe == 8'h00;
	endproperty
	property p_upper;
		ale && ext && cpu_req && !bus_width_pin |-> p3_drive.out[1] == !(cpu_addr[0] || cpu_word);
	endproperty
	property p_addr;
		ale && ext && cpu_req |-> {p2_drive.out, p1_drive.out, p0_drive.out} == cpu_addr;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("bus active after reset");
	a_float_on: assert property (p_float_on) else $error("float late or early");
	a_float_off: assert property (p_float_off) else $error("unfloat late or early");
	a_grant_idle: assert property (p_grant_idle) else $error("grant during access");
	a_stall: assert property (p_stall) else $error("strobes moved in stall");
	a_read_lanes: assert property (p_read_lanes) else $error("lanes driven in read");
	a_upper: assert property (p_upper) else $error("upper lane wrong");
	a_addr: assert property (p_addr) else $error("address pins wrong");
endmodule
bind ext_bus_ctrl ext_bus_ctrl_checker u_checker (.aclk, .aresetn, .cpu_req, .cpu_addr,
	.cpu_word, .bus_width_pin, .standby_in, .p4_in, .p0_drive, .p1_drive, .p2_drive,
	.p3_drive, .enable_out);
`default_nettype wire

// file: dv/ext_mem_model.sv
`default_nettype none
module ext_mem_model (
	input wire logic aclk,
	input wire bus_mode_pkg::pin_drive_t p0_drive,
	input wire bus_mode_pkg::pin_drive_t p1_drive,
	input wire bus_mode_pkg::pin_drive_t p2_drive,
	input wire bus_mode_pkg::pin_drive_t p3_drive,
	input wire bus_mode_pkg::pin_drive_t p4_drive,
	input wire logic enable_out,
	input wire logic hold_req,
	input wire logic slow,
	output logic [7:0] p0_in,
	output logic [7:0] p1_in,
	output logic [7:0] p2_in,
	output logic [7:0] p3_in,
	output logic [7:0] p4_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import bus_mode_pkg::*;
	logic [23:0] lat_addr = 24'h000000;
	logic [15:0] mem [128];
	logic [3:0] stall_cnt = 4'h0;
	logic bus;
	logic rd_drv;
	logic wr_term;
	logic wait_n;
	logic [6:0] idx;
	assign bus = p0_drive.oe == 8'hFF;
	assign idx = lat_addr[7:1];
	assign rd_drv = bus && !enable_out && p3_drive.out[0];
	assign wr_term = bus && !enable_out && !p3_drive.out[0];
	assign wait_n = !(slow && !enable_out && stall_cnt < 4'h8);
	////////////////////////////////////////
	// Released pins show the inverse of the last value, never a stale copy
	assign p0_in = p0_drive.out ^ ~p0_drive.oe;
	assign p1_in = rd_drv ? mem[idx][15:8] : p1_drive.out ^ ~p1_drive.oe;
	assign p2_in = rd_drv ? mem[idx][7:0] : p2_drive.out ^ ~p2_drive.oe;
	assign p3_in = p3_drive.out ^ ~p3_drive.oe;
	assign p4_in = {p4_drive.out[7:2] ^ ~p4_drive.oe[7:2], wait_n, !hold_req};
	always_ff @(posedge aclk)
	begin
		if (p3_drive.out[2] && bus) lat_addr <= {p2_drive.out, p1_drive.out, p0_drive.out};
		if (wr_term && !p3_drive.out[1]) mem[idx][15:8] <= p1_in;
		if (wr_term && !lat_addr[0]) mem[idx][7:0] <= p2_in;
		stall_cnt <= enable_out ? 4'h0 : stall_cnt + {3'h0, stall_cnt != 4'hF};
	end
endmodule
`default_nettype wire

// file: dv/processor_mode_external_bus_test.sv
`default_nettype none
module processor_mode_external_bus_test;
	timeunit 1ns;
	timeprecision 1ns;
	import bus_mode_pkg::*;
	localparam logic [23:0] EXT = 24'h010000;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, mode_strap_pin = 1'h0, mode_strap_hv = 1'h0;
	logic bus_width_pin = 1'h0, bus_width_hv = 1'h0, cpu_req = 1'h0, cpu_write = 1'h0;
	logic cpu_word = 1'h0, standby_in = 1'h0, hold_req = 1'h0, slow = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [23:0] cpu_addr = 24'h0;
	logic [15:0] cpu_wdata = 16'h0, int_rdata = 16'h0;
	eval_flags_t eval_in = '0;
	logic awready, wready, bvalid, arready, rvalid, cpu_ack, enable_out;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic [15:0] cpu_rdata, got, d;
	logic [7:0] p0_in, p1_in, p2_in, p3_in, p4_in;
	pin_drive_t p0_drive, p1_drive, p2_drive, p3_drive, p4_drive;
	logic [15:0] exp_mem [8];
	int error_cnt = 0, num_checks = 0, cyc = 0, tog = 0, stall_tog = 0, k, lo_cnt;
	logic up_lo;
	ext_bus_ctrl DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
		.rdata, .rresp, .mode_strap_pin, .mode_strap_hv, .bus_width_pin, .bus_width_hv,
		.cpu_req, .cpu_addr, .cpu_write, .cpu_word, .cpu_wdata, .int_rdata, .cpu_ack,
		.cpu_rdata, .standby_in, .eval_in, .p0_in, .p1_in, .p2_in, .p3_in, .p4_in, .p0_drive,
		.p1_drive, .p2_drive, .p3_drive, .p4_drive, .enable_out);
	ext_mem_model PEER (.aclk, .p0_drive, .p1_drive, .p2_drive, .p3_drive, .p4_drive,
		.enable_out, .hold_req, .slow, .p0_in, .p1_in, .p2_in, .p3_in, .p4_in);
	////////////////////////////////////////
	always #25 aclk = ~aclk;
	always @(p4_drive.out[2])
	begin
		tog++;
		if (p4_in[1] === 1'h0) stall_tog++;
	end
	task automatic final_report();
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Bounds a hang in any handshake wait
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Strobe low time of one access: data halves times clocks per half
	function automatic int lo_exp(input logic [3:0] len);
		lo_exp = (len - ADDR_HALVES) * (PHI_HALF_LAST + 1);
	endfunction
	task automatic reset_dut(input logic s, input logic h);
		aresetn <= 1'h0;
		standby_in <= 1'h0;
		mode_strap_pin <= s;
		mode_strap_hv <= h;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) bready <= 1'h0;
		end
		while (bready);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			rd = rvalid ? rdata : rd;
			rs = rvalid ? rresp : rs;
			if (rvalid) rready <= 1'h0;
		end
		while (rready);
	endtask
	task automatic access(input logic [23:0] a, input logic w, input logic wd, input logic [15:0] v);
		cpu_addr <= a;
		cpu_write <= w;
		cpu_word <= wd;
		cpu_wdata <= v;
		cpu_req <= 1'h1;
		lo_cnt = 0;
		up_lo = 1'h0;
		do
		begin
			@(posedge aclk);
			if (enable_out === 1'h0) lo_cnt++;
			if (p3_drive.out[1] === 1'h0) up_lo = 1'h1;
		end
		while (cpu_ack !== 1'h1);
		cpu_req <= 1'h0;
		got = cpu_rdata;
		// One idle edge so a following call never re-raises the request in this step
		@(posedge aclk);
	endtask
	////////////////////////////////////////
	initial
	begin
		k = $urandom(40);
		reset_dut(1'h1, 1'h0);
		rd_reg(OFS_STATUS);
		chk(rd[1:0], MODE_MICRO);
		rd_reg(8'h30);
		chk(rs, RESP_SLVERR);
		tog = 0;
		repeat (40) @(posedge aclk);
		chk(tog > 0, 1);
		for (int i = 0; i < 8; i++)
		begin
			exp_mem[i] = 16'($urandom);
			access({EXT[23:4], i[2:0], 1'h0}, 1'h1, 1'h1, exp_mem[i]);
		end
		// Byte writes land in one lane only, so neighbours must survive
		for (int i = 0; i < 12; i++)
		begin
			k = $urandom % 16;
			d = 16'($urandom);
			access({EXT[23:4], k[3:0]}, 1'h1, 1'h0, d);
			if (k % 2) exp_mem[k / 2][15:8] = d[15:8];
			else exp_mem[k / 2][7:0] = d[7:0];
		end
		for (int i = 0; i < 8; i++)
		begin
			slow <= i[0];
			access({EXT[23:4], i[2:0], 1'h0}, 1'h0, 1'h1, 16'h0);
			chk(got, exp_mem[i]);
		end
		chk(stall_tog > 0, 1);
		int_rdata <= 16'($urandom);
		access(24'h000100, 1'h0, 1'h1, 16'h0);
		chk(got, int_rdata);
		slow <= 1'h0;
		hold_req <= 1'h1;
		do @(posedge aclk); while (p3_drive.out[3] !== 1'h0);
		repeat (8) @(posedge aclk);
		chk({p0_drive.oe, p3_drive.oe[1:0]}, 10'h0);
		hold_req <= 1'h0;
		repeat (12) @(posedge aclk);
		chk(p0_drive.oe, 8'hFF);
		wr(OFS_OSC0, 32'h40);
		wr(OFS_GPIO4, 32'h0404);
		repeat (4) @(posedge aclk);
		tog = 0;
		repeat (40) @(posedge aclk);
		chk({31'(tog), p4_drive.out[2]}, 32'h1);
		wr(OFS_OSC0, 32'h0);
		standby_in <= 1'h1;
		repeat (4) @(posedge aclk);
		chk(enable_out, 1'h1);
		wr(OFS_PFC, 32'h1);
		wr(OFS_OSC0, 32'h40);
		repeat (4) @(posedge aclk);
		chk(enable_out, 1'h0);
		reset_dut(1'h0, 1'h0);
		rd_reg(OFS_STATUS);
		chk({rd[1:0], p0_drive.oe}, 10'h0);
		wr(OFS_OSC0, 32'h40);
		repeat (8) @(posedge aclk);
		chk(enable_out, 1'h0);
		wr(OFS_OSC0, 32'h0);
		wr(OFS_MODE0, 32'h01);
		repeat (4) @(posedge aclk);
		chk(p0_drive.oe, 8'hFF);
		access(EXT, 1'h1, 1'h1, 16'hA55A);
		chk(lo_cnt, lo_exp(LEN_WAIT20));
		wr(OFS_MODE1, 32'h1);
		access(EXT, 1'h0, 1'h1, 16'h0);
		chk(got, 16'hA55A);
		chk(lo_cnt, lo_exp(LEN_WAIT15));
		wr(OFS_MODE0, 32'h05);
		access(EXT, 1'h0, 1'h1, 16'h0);
		chk(lo_cnt, lo_exp(LEN_NOWAIT));
		wr(OFS_OSC0, 32'h40);
		access(24'h000100, 1'h0, 1'h1, 16'h0);
		chk(lo_cnt, 0);
		chk(got, int_rdata);
		wr(OFS_MODE0, 32'h02);
		rd_reg(OFS_STATUS);
		chk(rd[1:0], MODE_MICRO);
		reset_dut(1'h0, 1'h1);
		rd_reg(OFS_STATUS);
		chk(rd[1:0], MODE_EVAL);
		eval_in <= eval_flags_t'(4'($urandom));
		repeat (4) @(posedge aclk);
		chk(p4_drive.out[6:3], {eval_in.opcode_valid, eval_in.data_valid, eval_in.queue_flush,
			eval_in.width_flag});
		chk(p4_drive.oe[7:2], 6'h1F);
		bus_width_pin <= 1'h1;
		access(EXT | 24'h1, 1'h1, 1'h0, 16'hC3C3);
		access(P4_DATA_ADDR, 1'h0, 1'h1, 16'h0);
		chk(up_lo, 1'h1);
		chk(lo_cnt, lo_exp(LEN_NOWAIT));
		access(EXT, 1'h0, 1'h1, 16'h0);
		chk(up_lo, 1'h0);
		bus_width_pin <= 1'h0;
		access(EXT, 1'h0, 1'h1, 16'h0);
		chk(got[15:8], 8'hC3);
		final_report();
	end
endmodule
`default_nettype wire
